// [include/otpe_pkg.sv]
// constants and types of the one-time-programmable array controller
// assumes a 40 MHz ref_clk and an AXI4-Lite register path with 32-bit data
package otpe_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   // least programming time in milliseconds
   localparam int PROG_TIME_MS = 5;
   // least time in whole cycles, at least one
   localparam int PROG_CYCLES_DEF = (PROG_TIME_MS * (CLK_HZ / 1000) + 0) < 1 ? 1 :
      PROG_TIME_MS * (CLK_HZ / 1000);

   // ----------------------------------------------------------------
   // memory sizes
   // ----------------------------------------------------------------
   localparam int EPROM_BYTES = 15168;
   localparam int VECTOR_BYTES = 14;
   localparam int EEPROM_BYTES = 256;
   localparam int ARR_AW = 14;
   localparam int SLOT_COUNT = 8;
   localparam int SLOT_BITS = 3;
   localparam logic [7:0] ERASED_BYTE = 8'h00;
   localparam logic [ARR_AW-1:0] VECTOR_BASE = ARR_AW'(EPROM_BYTES - VECTOR_BYTES);
   localparam logic [ARR_AW-1:0] ARR_LIMIT = ARR_AW'(EPROM_BYTES);

   // ----------------------------------------------------------------
   // register map (printed offset is an index, byte address is 4x)
   // ----------------------------------------------------------------
   localparam int AXI_AW = 12;
   localparam logic [AXI_AW-3:0] CTRL_INDEX = 10'h007;
   localparam logic [AXI_AW-3:0] STAT_INDEX = 10'h008;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int LATCH_BIT = 5;
   localparam int PGM_BIT = 4;
   localparam int EXTERNAL_CLOCK_OUT_ENABLE_BIT = 3;
   localparam int ST_SUPPLY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_LOADED_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // array mode
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OTPE_READ = 3'h0,
      OTPE_LOAD = 3'h1,
      OTPE_BURN = 3'h3,
      OTPE_COMMIT = 3'h2,
      OTPE_DONE = 3'h6
   } otpe_mode_e;
endpackage

// [rtl/otpe_mem.sv]
// byte array with registered read and bit-accumulating write
// assumes one clock; contents start erased, reset does not touch them
module otpe_mem
   import otpe_pkg::*;
#(
   parameter int DEPTH = EPROM_BYTES,
   parameter int AW = ARR_AW
) (
   // clock
   input wire logic ref_clk,
   // read port
   input wire logic rdEn,
   input wire logic [AW-1:0] rdAddr,
   output logic [7:0] rdData,
   // write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [7:0] wrData
);
   logic [7:0] cells [DEPTH];

   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         cells[i] = ERASED_BYTE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (wrEn) begin
         cells[wrAddr] <= cells[wrAddr] | wrData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rdEn) begin
         rdData <= cells[rdAddr];
      end
   end
endmodule

// [rtl/otpe_ctrl.sv]
// read/program controller of the one-time-programmable code array
// assumes CPU strobes on ref_clk; pins arrive asynchronously
//
// How it works
// - clearing latch enable clears program enable
// - reads while latching flagged invalid
// - no vector loads while latching
// - boot routines disabled while latching
// - stop entry forces read mode
// - unprogrammed byte reads zero
// - reprogramming only ORs in ones
// - eight bytes share upper address bits
// - stop with watchdog running resets
// - array sizes fixed as documented
// - program enable needs latch and byte
// - stop and resets clear latch enable
// - latching writes capture address and data
//
// Added by the designer: the AXI4-Lite slave port.
module otpe_ctrl
   import otpe_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // axi4-lite write address
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data and response
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu array port
   input wire logic arrayRdEn,
   input wire logic vectorFetch,
   input wire logic arrayWrEn,
   input wire logic [ARR_AW-1:0] arrayAddr,
   input wire logic [7:0] arrayWrData,
   output logic [7:0] arrayRdData,
   output logic arrayRdStrobe,
   output logic arrayRdGood,
   output logic vectorLoad,
   // cpu mode signals
   input wire logic stopExec,
   input wire logic watchdogRun,
   output logic haltEnter,
   output logic watchdogReset,
   output logic bootRomEnable,
   output logic eclkEnable,
   // pins
   input wire logic extResetPin_n,
   input wire logic supplyPin,
   output logic programArmed
);
   localparam int TW = $clog2(PROG_CYCLES + 1);
   localparam logic [TW-1:0] TIMER_LAST = TW'(PROG_CYCLES - 1);
   localparam logic [SLOT_BITS-1:0] SLOT_LAST = SLOT_BITS'(SLOT_COUNT - 1);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic extRstMeta_n;
   logic extRstSync_n;
   logic supplyMeta;
   logic supplySync;

   always_ff @(posedge ref_clk) begin
      extRstMeta_n <= extResetPin_n;
      extRstSync_n <= extRstMeta_n;
      supplyMeta <= supplyPin;
      supplySync <= supplyMeta;
   end

   // ----------------------------------------------------------------
   // axi4-lite write path
   // ----------------------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [AXI_AW-1:0] awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic doWrite;
   logic ctrlWrite;

   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign ctrlWrite = doWrite && (awAddrHeld[AXI_AW-1:2] == CTRL_INDEX) && wStrbHeld[0];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         awHeld <= 1'b0;
         awAddrHeld <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awHeld <= 1'b1;
         awAddrHeld <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end else if (!awHeld && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_wready <= 1'b0;
         wHeld <= 1'b0;
         wDataHeld <= '0;
         wStrbHeld <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wHeld <= 1'b1;
         wDataHeld <= s_axi_wdata;
         wStrbHeld <= s_axi_wstrb;
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end else if (!wHeld && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // unmapped writes are dropped and answered with slverr
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         if ((awAddrHeld[AXI_AW-1:2] == CTRL_INDEX) || (awAddrHeld[AXI_AW-1:2] == STAT_INDEX)) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   logic latchEn;
   logic progEn;
   logic next_latchEn;
   logic next_progEn;
   logic clearLatch;
   logic anyLoaded;
   logic progDone;
   otpe_mode_e mode;
   otpe_mode_e next_mode;

   // stop and external reset drop the latch
   // stop also returns the array to read mode
   assign clearLatch = stopExec || !extRstSync_n ||
      (ctrlWrite && !wDataHeld[LATCH_BIT]);

   always_comb begin
      next_latchEn = latchEn;
      if (clearLatch) begin
         next_latchEn = 1'b0;
      end else if (ctrlWrite) begin
         next_latchEn = wDataHeld[LATCH_BIT];
      end
   end

   always_comb begin
      next_progEn = progEn;
      if (!next_latchEn) begin
         next_progEn = 1'b0;
      // set only after latch and a loaded byte
      end else if (ctrlWrite && wDataHeld[PGM_BIT] && latchEn && anyLoaded) begin
         next_progEn = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         latchEn <= CTRL_RESET[LATCH_BIT];
         progEn <= CTRL_RESET[PGM_BIT];
      end else begin
         latchEn <= next_latchEn;
         progEn <= next_progEn;
      end
   end

   // board may switch the supply once this is high
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         programArmed <= 1'b0;
      end else begin
         programArmed <= next_progEn;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         eclkEnable <= CTRL_RESET[EXTERNAL_CLOCK_OUT_ENABLE_BIT];
      end else if (!extRstSync_n) begin
         eclkEnable <= CTRL_RESET[EXTERNAL_CLOCK_OUT_ENABLE_BIT];
      end else if (ctrlWrite) begin
         eclkEnable <= wDataHeld[EXTERNAL_CLOCK_OUT_ENABLE_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bootRomEnable <= 1'b0;
      end else begin
         bootRomEnable <= !next_latchEn;
      end
   end

   // ----------------------------------------------------------------
   // stop handling
   // ----------------------------------------------------------------
   // running watchdog turns stop into a reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         haltEnter <= 1'b0;
         watchdogReset <= 1'b0;
      end else begin
         haltEnter <= stopExec && !watchdogRun;
         watchdogReset <= stopExec && watchdogRun;
      end
   end

   // ----------------------------------------------------------------
   // latch slots
   // ----------------------------------------------------------------
   logic [SLOT_COUNT-1:0] slotValid;
   logic [7:0] slotData [SLOT_COUNT];
   logic [ARR_AW-1:SLOT_BITS] groupAddr;
   logic loadWrite;
   logic newGroup;

   // writes latch only in the load mode
   assign loadWrite = arrayWrEn && latchEn && !progEn && !clearLatch &&
      (arrayAddr < ARR_LIMIT);
   // a different upper address starts a new group
   assign newGroup = anyLoaded && (arrayAddr[ARR_AW-1:SLOT_BITS] != groupAddr);
   assign anyLoaded = |slotValid;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         groupAddr <= '0;
      end else if (loadWrite) begin
         groupAddr <= arrayAddr[ARR_AW-1:SLOT_BITS];
      end
   end

   // one slot per low address pattern
   for (genvar i = 0; i < SLOT_COUNT; i++) begin : g_slot
      always_ff @(posedge ref_clk) begin
         if (reset || !next_latchEn) begin
            slotValid[i] <= 1'b0;
            slotData[i] <= ERASED_BYTE;
         end else if (loadWrite && (arrayAddr[SLOT_BITS-1:0] == SLOT_BITS'(i))) begin
            slotValid[i] <= 1'b1;
            slotData[i] <= arrayWrData;
         end else if (loadWrite && newGroup) begin
            slotValid[i] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // programming sequence
   // ----------------------------------------------------------------
   logic [TW-1:0] burnTimer;
   logic [SLOT_BITS-1:0] commitIdx;
   logic memWrEn;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         OTPE_READ: begin
            if (next_latchEn) next_mode = OTPE_LOAD;
         end
         OTPE_LOAD: begin
            if (!next_latchEn) next_mode = OTPE_READ;
            else if (next_progEn) next_mode = OTPE_BURN;
         end
         OTPE_BURN: begin
            if (!next_latchEn) next_mode = OTPE_READ;
            else if (supplySync && (burnTimer == TIMER_LAST)) next_mode = OTPE_COMMIT;
         end
         OTPE_COMMIT: begin
            if (!next_latchEn) next_mode = OTPE_READ;
            else if (commitIdx == SLOT_LAST) next_mode = OTPE_DONE;
         end
         OTPE_DONE: begin
            if (!next_latchEn) next_mode = OTPE_READ;
         end
         default: next_mode = OTPE_READ;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mode <= OTPE_READ;
      end else begin
         mode <= next_mode;
      end
   end

   // burn time only accumulates while the supply is up
   always_ff @(posedge ref_clk) begin
      if (reset || mode != OTPE_BURN) begin
         burnTimer <= '0;
      end else if (supplySync && burnTimer != TIMER_LAST) begin
         burnTimer <= burnTimer + TW'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || mode != OTPE_COMMIT) begin
         commitIdx <= '0;
      end else begin
         commitIdx <= commitIdx + SLOT_BITS'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || !next_latchEn) begin
         progDone <= 1'b0;
      end else if (next_mode == OTPE_DONE) begin
         progDone <= 1'b1;
      end
   end

   assign memWrEn = (mode == OTPE_COMMIT) && slotValid[commitIdx] && next_latchEn;

   // ----------------------------------------------------------------
   // array and read path
   // ----------------------------------------------------------------
   logic [7:0] memRdData;
   logic rdPend;
   logic rdVec;
   logic rdBad;
   logic rdOut;

   // array sized to the code bytes
   otpe_mem #(
      .DEPTH(EPROM_BYTES),
      .AW(ARR_AW)
   ) u_mem (
      .ref_clk(ref_clk),
      .rdEn(arrayRdEn),
      .rdAddr(arrayAddr),
      .rdData(memRdData),
      .wrEn(memWrEn),
      .wrAddr({groupAddr, commitIdx}),
      .wrData(slotData[commitIdx])
   );

   // latch state captured at request time
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdPend <= 1'b0;
         rdVec <= 1'b0;
         rdBad <= 1'b0;
         rdOut <= 1'b0;
      end else begin
         rdPend <= arrayRdEn;
         rdVec <= arrayRdEn && vectorFetch && (arrayAddr >= VECTOR_BASE) &&
            (arrayAddr < ARR_LIMIT);
         rdBad <= latchEn || (arrayAddr >= ARR_LIMIT);
         rdOut <= latchEn;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         arrayRdData <= ERASED_BYTE;
         arrayRdStrobe <= 1'b0;
         arrayRdGood <= 1'b0;
         vectorLoad <= 1'b0;
      end else begin
         arrayRdStrobe <= rdPend;
         arrayRdGood <= rdPend && !rdBad;
         // vectors are not loaded while latching
         vectorLoad <= rdVec && !rdOut;
         arrayRdData <= (rdPend && !rdBad) ? memRdData : ERASED_BYTE;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read path
   // ----------------------------------------------------------------
   logic [31:0] rdWord;
   logic rdHit;

   always_comb begin
      rdWord = '0;
      rdHit = 1'b1;
      if (s_axi_araddr[AXI_AW-1:2] == CTRL_INDEX) begin
         rdWord[LATCH_BIT] = latchEn;
         rdWord[PGM_BIT] = progEn;
         rdWord[EXTERNAL_CLOCK_OUT_ENABLE_BIT] = eclkEnable;
      end else if (s_axi_araddr[AXI_AW-1:2] == STAT_INDEX) begin
         rdWord[ST_SUPPLY_BIT] = supplySync;
         rdWord[ST_DONE_BIT] = progDone;
         rdWord[ST_LOADED_BIT] = anyLoaded;
         rdWord[ST_BUSY_BIT] = (mode == OTPE_BURN) || (mode == OTPE_COMMIT);
      end else begin
         rdHit = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdWord;
         s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// [sim/otpe_props.sv]
// port-level checker of the array controller
// assumes it is bound to otpe_ctrl, one clock domain, sync reset
module otpe_props
   import otpe_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // array port
   input wire logic arrayRdEn,
   input wire logic [7:0] arrayRdData,
   input wire logic arrayRdStrobe,
   input wire logic arrayRdGood,
   input wire logic vectorLoad,
   // mode signals
   input wire logic stopExec,
   input wire logic watchdogRun,
   input wire logic haltEnter,
   input wire logic watchdogReset,
   input wire logic bootRomEnable,
   input wire logic programArmed
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_rd_lat; arrayRdEn |-> ##2 arrayRdStrobe; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read strobe late");
   property p_bad_zero; arrayRdStrobe && !arrayRdGood |-> arrayRdData == 8'h00; endproperty
   a_bad_zero: assert property (p_bad_zero) else $error("invalid read not zero");
   property p_latch_bad;
      arrayRdStrobe && !$past(bootRomEnable) && !$past(bootRomEnable, 2) |-> !arrayRdGood;
   endproperty
   a_latch_bad: assert property (p_latch_bad) else $error("read good while latched");
   property p_vec; vectorLoad |-> arrayRdStrobe && arrayRdGood; endproperty
   a_vec: assert property (p_vec) else $error("vector load while invalid");
   property p_halt; stopExec && !watchdogRun |=> haltEnter && !watchdogReset; endproperty
   a_halt: assert property (p_halt) else $error("halt not entered");
   property p_halt_pulse; haltEnter |=> !haltEnter; endproperty
   a_halt_pulse: assert property (p_halt_pulse) else $error("halt pulse too long");
   property p_watchdog_run_bit; stopExec && watchdogRun |=> watchdogReset && !haltEnter; endproperty
   a_watchdog_run_bit: assert property (p_watchdog_run_bit) else $error("stop did not reset");
   property p_stop_clr; stopExec |=> bootRomEnable && !programArmed; endproperty
   a_stop_clr: assert property (p_stop_clr) else $error("stop left latch set");
   property p_pgm_latch; $rose(programArmed) |-> !$past(bootRomEnable); endproperty
   a_pgm_latch: assert property (p_pgm_latch) else $error("armed without latch");
   property p_clr_pgm; bootRomEnable |-> !programArmed; endproperty
   a_clr_pgm: assert property (p_clr_pgm) else $error("armed with latch clear");
endmodule

bind otpe_ctrl otpe_props u_props (.ref_clk, .reset, .arrayRdEn, .arrayRdData, .arrayRdStrobe,
   .arrayRdGood, .vectorLoad, .stopExec, .watchdogRun, .haltEnter, .watchdogReset,
   .bootRomEnable, .programArmed);

// [sim/otpe_board.sv]
// programming board model switching the array supply
// assumes programArmed from the controller on the same clock
module otpe_board
#(
   parameter int FAST_WAIT = 2,
   parameter int SLOW_WAIT = 20
) (
   // clock
   input wire logic ref_clk,
   // board control
   input wire logic slow,
   // pins
   input wire logic programArmed,
   output logic supplyPin
);
   timeunit 1ns;
   timeprecision 1ps;
   int waitCount = 0;
   initial supplyPin = 1'h0;
   always @(posedge ref_clk) begin
      if (!programArmed) begin
         waitCount <= 0;
         supplyPin <= 1'h0;
      end else if (waitCount < (slow ? SLOW_WAIT : FAST_WAIT)) begin
         waitCount <= waitCount + 1;
      end else begin
         supplyPin <= 1'h1;
      end
   end
endmodule

// [sim/otpe_ctrl_tb.sv]
// self-checking bench of the array controller
// assumes otpe_pkg, the board model and the bound checker
module otpe_ctrl_tb
   import otpe_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // short burn keeps the run brief
   localparam int PCYC = 16;
   localparam logic [11:0] CTRL = {CTRL_INDEX, 2'h0};
   localparam logic [11:0] STAT = {STAT_INDEX, 2'h0};
   logic ref_clk = 1'h0;
   logic reset = 1'h1;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic arrayRdEn = 1'h0, vectorFetch = 1'h0, arrayWrEn = 1'h0;
   logic stopExec = 1'h0, watchdogRun = 1'h0, extResetPin_n = 1'h1, slow = 1'h0;
   logic [ARR_AW-1:0] arrayAddr = 14'h0;
   logic [7:0] arrayWrData = 8'h0, arrayRdData;
   logic arrayRdStrobe, arrayRdGood, vectorLoad, haltEnter, watchdogReset;
   logic bootRomEnable, eclkEnable, programArmed, supplyPin;
   int errors = 0, check_count = 0, cycles = 0;

   otpe_ctrl #(.PROG_CYCLES(PCYC)) uut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .arrayRdEn, .vectorFetch,
      .arrayWrEn, .arrayAddr, .arrayWrData, .arrayRdData, .arrayRdStrobe, .arrayRdGood,
      .vectorLoad, .stopExec, .watchdogRun, .haltEnter, .watchdogReset, .bootRomEnable,
      .eclkEnable, .extResetPin_n, .supplyPin, .programArmed);
   otpe_board board (.ref_clk, .slow, .programArmed, .supplyPin);

   initial forever #12.5 ref_clk = ~ref_clk;
   // a hang counts as a mismatch
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         errors++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic wr(input logic [31:0] d);
      axw(CTRL, d, rs);
      chk("bresp", rs, RESP_OKAY);
   endtask
   task automatic rdchk(input string nm, input logic [31:0] exp);
      axr(CTRL, rv, rs);
      chk(nm, rv, exp);
      chk("rresp", rs, RESP_OKAY);
   endtask
   task automatic aw(input logic [ARR_AW-1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      arrayAddr <= a;
      arrayWrData <= d;
      arrayWrEn <= 1'h1;
      @(posedge ref_clk);
      arrayWrEn <= 1'h0;
   endtask
   task automatic ar(input logic [ARR_AW-1:0] a, input logic vf, input logic [7:0] ed,
      input logic eg, input logic ev);
      @(posedge ref_clk);
      arrayAddr <= a;
      vectorFetch <= vf;
      arrayRdEn <= 1'h1;
      @(posedge ref_clk);
      arrayRdEn <= 1'h0;
      vectorFetch <= 1'h0;
      @(posedge ref_clk);
      #1;
      chk("rd strobe", arrayRdStrobe, 1);
      chk("rd data", arrayRdData, ed);
      chk("rd good", arrayRdGood, eg);
      chk("vector", vectorLoad, ev);
   endtask
   task automatic stop(input logic wd);
      @(posedge ref_clk);
      watchdogRun <= wd;
      stopExec <= 1'h1;
      @(posedge ref_clk);
      stopExec <= 1'h0;
      #1;
      chk("halt", haltEnter, !wd);
      chk("watchdog_run_bit reset", watchdogReset, wd);
      chk("boot rom", bootRomEnable, 1);
   endtask
   // arm, wait for the board and the burn, then leave latch mode
   task automatic burn(input logic sl);
      int n;
      n = 0;
      slow <= sl;
      wr(32'h30);
      do begin
         axr(STAT, rv, rs);
         n++;
      end while (!rv[ST_DONE_BIT] && n < 60);
      chk("done", rv[ST_DONE_BIT], 1);
      chk("supply seen", rv[ST_SUPPLY_BIT], 1);
      chk("armed", programArmed, 1);
      wr(32'h00);
      rdchk("ctrl end", 32'h00);
      chk("disarmed", programArmed, 0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'h0;
      rdchk("ctrl reset", CTRL_RESET);
      axr(12'hFFC, rv, rs);
      chk("unmapped rresp", rs, RESP_SLVERR);
      axw(12'hFF0, 32'h30, rs);
      chk("unmapped bresp", rs, RESP_SLVERR);
      wr(32'h08);
      chk("external_clock_out_enable", eclkEnable, 1);
      wr(32'h18);
      rdchk("pgm no latch", 32'h08);
      wr(32'h30);
      rdchk("pgm no byte", 32'h20);
      chk("boot off", bootRomEnable, 0);
      // no code fetch from array while latched
      ar(14'h0100, 0, 8'h00, 0, 0);
      ar(VECTOR_BASE, 1, 8'h00, 0, 0);
      for (int i = 0; i < SLOT_COUNT; i++) aw(14'h0100 | 14'(i), 8'(i + 1));
      burn(1'h0);
      for (int i = 0; i < SLOT_COUNT; i++) ar(14'h0100 | 14'(i), 0, 8'(i + 1), 1, 0);
      wr(32'h20);
      aw(14'h0200, 8'h55);
      aw(14'h0100, 8'hF0);
      burn(1'h1);
      ar(14'h0100, 0, 8'hF1, 1, 0);
      ar(14'h0200, 0, 8'h00, 1, 0);
      ar(14'h0101, 0, 8'h02, 1, 0);
      ar(ARR_LIMIT - 14'h1, 0, ERASED_BYTE, 1, 0);
      ar(ARR_LIMIT, 0, 8'h00, 0, 0);
      ar(VECTOR_BASE, 1, 8'h00, 1, 1);
      wr(32'h20);
      aw(14'h0300, 8'hAA);
      wr(32'h30);
      stop(1'h0);
      chk("abort armed", programArmed, 0);
      rdchk("ctrl stop", 32'h00);
      ar(14'h0300, 0, 8'h00, 1, 0);
      wr(32'h20);
      stop(1'h1);
      rdchk("ctrl watchdog_run_bit", 32'h00);
      wr(32'h28);
      @(posedge ref_clk);
      extResetPin_n <= 1'h0;
      repeat (6) @(posedge ref_clk);
      extResetPin_n <= 1'h1;
      repeat (4) @(posedge ref_clk);
      rdchk("ctrl pin reset", 32'h00);
      close_out();
   end
endmodule
